// file: design/prc_rtc_top.sv
// ptp real-time clock with rate adjustment and message config, on an axi4-lite slave
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/10ps
module prc_rtc_top
  import prc_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input  wire logic              ref_clk_i,
  input  wire logic              reset_n_i,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic [2:0]        s_axi_awprot_i,
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire logic [31:0]       s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  output logic [1:0]             s_axi_bresp_o,
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic [2:0]        s_axi_arprot_i,
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  output logic [31:0]            s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  output prc_time_t              time_o,
  output logic                   clk_running_o,
  output logic                   temp_adjust_active_o,
  output logic                   cont_adjust_active_o,
  output logic                   ptp_mode_en_o,
  output logic                   detect_l2_en_o,
  output logic                   detect_ipv4_en_o,
  output logic                   detect_ipv6_en_o,
  output logic                   p2p_mode_o,
  output logic                   host_master_o
);

  localparam int HIGH_ADDR_LSB = IDX_W + 2;
  localparam logic [TICK_CNT_W-1:0] TICK_LAST = TICK_CNT_W'(TICK_DIV - 1);

  generate
    if (ADDR_W < HIGH_ADDR_LSB || ADDR_W > 32) begin : g_bad_addr_w
      $error("ADDR_W must lie between 14 and 32");
    end
    if (TICK_DIV < 2 || (REF_CLK_HZ % RTC_TICK_HZ) != 0) begin : g_bad_div
      $error("reference clock must be a whole multiple of the tick rate");
    end
  endgenerate

  prc_state_t state_reg;
  prc_state_t state_next;

  logic              tick;
  logic              adj_en;
  logic [31:0]       step_ns;
  logic [31:0]       step_sec;
  logic [31:0]       step_frac;
  logic [IDX_W-1:0]  wr_idx;
  logic              wr_hit;
  logic [15:0]       wr_old;
  logic [15:0]       wr_val;
  logic [IDX_W-1:0]  rd_idx;
  logic              rd_hit;
  logic [15:0]       rd_val;
  logic [16:0]       wr_look;
  logic [16:0]       rd_look;
  logic [31:0]       ar_addr;
  logic [32:0]       jump_sum;
  logic [32:0]       jump_dif;

  // readback of one register: bit 16 flags a mapped index
  function automatic logic [16:0] reg_read(input logic [IDX_W-1:0] idx);
    logic [15:0] ctrl;
    ctrl = 16'h0000;
    ctrl[CTRL_STEP_DIR_BIT] = state_reg.step_dir;
    ctrl[CTRL_CONT_BIT]     = state_reg.cont_adj;
    ctrl[CTRL_ENABLE_BIT]   = state_reg.clk_en;
    case (idx)
      IDX_CTRL:     reg_read = {1'b1, ctrl};
      IDX_PHASE:    reg_read = {1'b1, 13'h0000, state_reg.shadow.phase};
      IDX_NS_HI:    reg_read = {1'b1, state_reg.shadow.ns[31:16]};
      IDX_NS_LO:    reg_read = {1'b1, state_reg.shadow.ns[15:0]};
      IDX_SEC_HI:   reg_read = {1'b1, state_reg.shadow.sec[31:16]};
      IDX_SEC_LO:   reg_read = {1'b1, state_reg.shadow.sec[15:0]};
      IDX_RATE_HI:  reg_read = {1'b1, state_reg.rate_dir, state_reg.temp_active,
                                state_reg.rate[29:16]};
      IDX_RATE_LO:  reg_read = {1'b1, state_reg.rate[15:0]};
      IDX_DUR_HI:   reg_read = {1'b1, state_reg.dur[31:16]};
      IDX_DUR_LO:   reg_read = {1'b1, state_reg.dur[15:0]};
      IDX_MSG_CFG1: reg_read = {1'b1, state_reg.msg_cfg};
      default:      reg_read = 17'h00000;
    endcase
  endfunction

  // byte lanes 0 and 1 carry the 16-bit register; lanes 2 and 3 are ignored
  function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
                                             input logic [15:0] new_v,
                                             input logic [1:0]  strb);
    lane_merge[7:0]  = strb[0] ? new_v[7:0] : old_v[7:0];
    lane_merge[15:8] = strb[1] ? new_v[15:8] : old_v[15:8];
  endfunction

  assign tick    = (state_reg.tick_cnt == TICK_LAST);
  assign adj_en  = state_reg.cont_adj | state_reg.temp_active;
  assign ar_addr = 32'(s_axi_araddr_i);

  assign wr_idx  = state_reg.aw_addr[HIGH_ADDR_LSB-1:2];
  // a process, not an assign: the lookup reads state_reg inside the function
  always_comb begin
    wr_look = reg_read(wr_idx);
    rd_look = reg_read(rd_idx);
  end
  assign wr_hit  = (state_reg.aw_addr[31:HIGH_ADDR_LSB] == '0) && wr_look[16];
  assign wr_old  = wr_look[15:0];
  assign wr_val  = lane_merge(wr_old, state_reg.w_data, state_reg.w_strb);

  assign rd_idx  = ar_addr[HIGH_ADDR_LSB-1:2];
  assign rd_hit  = (ar_addr[31:HIGH_ADDR_LSB] == '0) && rd_look[16];
  assign rd_val  = rd_look[15:0];

  prc_time_step u_time_step (
    .ns_i      (state_reg.live.ns),
    .sec_i     (state_reg.live.sec),
    .frac_i    (state_reg.live_frac),
    .rate_i    (state_reg.rate),
    .adj_en_i  (adj_en),
    .add_dir_i (state_reg.rate_dir),
    .ns_o      (step_ns),
    .sec_o     (step_sec),
    .frac_o    (step_frac)
  );

  always_comb begin
    state_next = state_reg;
    jump_sum   = 33'h000000000;
    jump_dif   = 33'h000000000;

    // 25MHz tick from the 100MHz reference
    if (tick) begin
      state_next.tick_cnt = '0;
    end else begin
      state_next.tick_cnt = state_reg.tick_cnt + TICK_CNT_W'(1);
    end

    // the tick only moves time while software keeps the clock enabled
    if (tick && state_reg.clk_en) begin
      state_next.live.ns   = step_ns;
      state_next.live.sec  = step_sec;
      state_next.live_frac = step_frac;
      if (state_reg.temp_active) begin
        state_next.temp_cnt = state_reg.temp_cnt - 32'h1;
        if (state_reg.temp_cnt == 32'h1) begin
          state_next.temp_active = 1'b0;
        end
      end
    end

    // axi write channels are taken independently
    if (s_axi_awvalid_i && state_reg.awready) begin
      state_next.aw_have = 1'b1;
      state_next.aw_addr = 32'(s_axi_awaddr_i);
    end
    if (s_axi_wvalid_i && state_reg.wready) begin
      state_next.w_have = 1'b1;
      state_next.w_data = s_axi_wdata_i[15:0];
      state_next.w_strb = s_axi_wstrb_i[1:0];
    end
    if (state_reg.bvalid && s_axi_bready_i) begin
      state_next.bvalid = 1'b0;
    end

    // register write; it follows the tick so a software set beats a hardware end
    if (state_reg.aw_have && state_reg.w_have && !state_reg.bvalid) begin
      state_next.aw_have = 1'b0;
      state_next.w_have  = 1'b0;
      state_next.bvalid  = 1'b1;
      state_next.bresp   = wr_hit ? RESP_OKAY : RESP_SLVERR;
      if (wr_hit) begin
        case (wr_idx)
          IDX_CTRL: begin
            state_next.step_dir = wr_val[CTRL_STEP_DIR_BIT];
            state_next.cont_adj = wr_val[CTRL_CONT_BIT];
            state_next.clk_en   = wr_val[CTRL_ENABLE_BIT];
            if (wr_val[CTRL_READ_BIT]) begin
              state_next.shadow = state_reg.live;
            end
            if (wr_val[CTRL_STEP_BIT]) begin
              // step by the nanosecond shadow; values of a second or more are not served
              jump_sum = {1'b0, state_next.live.ns} + {1'b0, state_reg.shadow.ns};
              jump_dif = {1'b0, state_next.live.ns} - {1'b0, state_reg.shadow.ns};
              if (wr_val[CTRL_STEP_DIR_BIT]) begin
                if (jump_sum >= NS_PER_SEC) begin
                  state_next.live.ns  = 32'(jump_sum - NS_PER_SEC);
                  state_next.live.sec = state_next.live.sec + 32'h1;
                end else begin
                  state_next.live.ns = jump_sum[31:0];
                end
              end else if (jump_dif[32]) begin
                state_next.live.ns  = 32'(jump_dif + NS_PER_SEC);
                state_next.live.sec = state_next.live.sec - 32'h1;
              end else begin
                state_next.live.ns = jump_dif[31:0];
              end
            end
            if (wr_val[CTRL_LOAD_BIT]) begin
              state_next.live      = state_reg.shadow;
              state_next.live_frac = 32'h00000000;
            end
            if (wr_val[CTRL_RESET_BIT]) begin
              state_next.live      = '0;
              state_next.live_frac = 32'h00000000;
            end
          end
          IDX_PHASE:  state_next.shadow.phase = wr_val[PHASE_W-1:0];
          IDX_NS_HI:  state_next.shadow.ns[31:16] = wr_val;
          IDX_NS_LO:  state_next.shadow.ns[15:0] = wr_val;
          IDX_SEC_HI: state_next.shadow.sec[31:16] = wr_val;
          IDX_SEC_LO: state_next.shadow.sec[15:0] = wr_val;
          IDX_RATE_HI: begin
            state_next.rate[29:16] = wr_val[RATE_HI_MSB:0];
            state_next.rate_dir    = wr_val[RATE_DIR_BIT];
            // the mode bits sit in the upper lane; a low-lane write leaves them alone
            if (state_reg.w_strb[1] && wr_val[RATE_TEMP_BIT]) begin
              state_next.temp_cnt    = state_reg.dur;
              state_next.temp_active = (state_reg.dur != 32'h00000000);
            end else if (state_reg.w_strb[1]) begin
              state_next.temp_cnt    = 32'h00000000;
              state_next.temp_active = 1'b0;
            end
          end
          IDX_RATE_LO: state_next.rate[15:0] = wr_val;
          IDX_DUR_HI:  state_next.dur[31:16] = wr_val;
          IDX_DUR_LO:  state_next.dur[15:0] = wr_val;
          IDX_MSG_CFG1: begin
            state_next.msg_cfg = (state_reg.msg_cfg & ~MSG_RW_MASK)
                               | (wr_val & MSG_RW_MASK);
          end
          default: begin
          end
        endcase
      end
    end
    state_next.awready = !state_next.aw_have && !state_next.bvalid;
    state_next.wready  = !state_next.w_have && !state_next.bvalid;

    // read channel: data is latched at the address handshake
    if (state_reg.rvalid && s_axi_rready_i) begin
      state_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && state_reg.arready) begin
      state_next.rvalid = 1'b1;
      state_next.rdata  = rd_hit ? {16'h0000, rd_val} : 32'h00000000;
      state_next.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    state_next.arready = !state_next.rvalid;
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg         <= '0;
      state_reg.msg_cfg <= MSG_CFG_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign s_axi_awready_o      = state_reg.awready;
  assign s_axi_wready_o       = state_reg.wready;
  assign s_axi_bresp_o        = state_reg.bresp;
  assign s_axi_bvalid_o       = state_reg.bvalid;
  assign s_axi_arready_o      = state_reg.arready;
  assign s_axi_rdata_o        = state_reg.rdata;
  assign s_axi_rresp_o        = state_reg.rresp;
  assign s_axi_rvalid_o       = state_reg.rvalid;
  assign time_o               = state_reg.live;
  assign clk_running_o        = state_reg.clk_en;
  assign temp_adjust_active_o = state_reg.temp_active;
  assign cont_adjust_active_o = state_reg.cont_adj;
  assign ptp_mode_en_o        = state_reg.msg_cfg[MSG_PTP_EN_BIT];
  assign detect_l2_en_o       = state_reg.msg_cfg[MSG_L2_BIT];
  assign detect_ipv4_en_o     = state_reg.msg_cfg[MSG_IPV4_BIT];
  assign detect_ipv6_en_o     = state_reg.msg_cfg[MSG_IPV6_BIT];
  assign p2p_mode_o           = state_reg.msg_cfg[MSG_P2P_BIT];
  assign host_master_o        = state_reg.msg_cfg[MSG_MASTER_BIT];

endmodule

// file: design/prc_pkg.sv
// constants, field layouts and carrier types for the ptp real-time clock block
package prc_pkg;

  localparam int REF_CLK_HZ  = 100_000_000;
  localparam int RTC_TICK_HZ = 25_000_000;
  localparam int TICK_DIV    = REF_CLK_HZ / RTC_TICK_HZ;
  localparam int TICK_CNT_W  = $clog2(TICK_DIV);
  localparam int NOMINAL_NS  = 1_000_000_000 / RTC_TICK_HZ;

  localparam logic [32:0] NS_PER_SEC    = 33'h03b9aca00;
  localparam logic [32:0] NOMINAL_NS_33 = 33'(NOMINAL_NS);

  // register indices; the byte address is four times the index
  localparam int IDX_W = 12;
  localparam logic [IDX_W-1:0] IDX_CTRL      = 12'h500;
  localparam logic [IDX_W-1:0] IDX_PHASE     = 12'h502;
  localparam logic [IDX_W-1:0] IDX_NS_HI     = 12'h504;
  localparam logic [IDX_W-1:0] IDX_NS_LO     = 12'h506;
  localparam logic [IDX_W-1:0] IDX_SEC_HI    = 12'h508;
  localparam logic [IDX_W-1:0] IDX_SEC_LO    = 12'h50a;
  localparam logic [IDX_W-1:0] IDX_RATE_HI   = 12'h50c;
  localparam logic [IDX_W-1:0] IDX_RATE_LO   = 12'h50e;
  localparam logic [IDX_W-1:0] IDX_DUR_HI    = 12'h510;
  localparam logic [IDX_W-1:0] IDX_DUR_LO    = 12'h512;
  localparam logic [IDX_W-1:0] IDX_MSG_CFG1  = 12'h514;

  // clock control fields
  localparam int CTRL_RESET_BIT    = 0;
  localparam int CTRL_ENABLE_BIT   = 1;
  localparam int CTRL_CONT_BIT     = 2;
  localparam int CTRL_LOAD_BIT     = 3;
  localparam int CTRL_READ_BIT     = 4;
  localparam int CTRL_STEP_DIR_BIT = 5;
  localparam int CTRL_STEP_BIT     = 6;

  // rate high word fields, and the phase field width
  localparam int RATE_DIR_BIT  = 15;
  localparam int RATE_TEMP_BIT = 14;
  localparam int RATE_HI_MSB   = 13;
  localparam int PHASE_W       = 3;

  // message config 1 fields
  localparam int MSG_PTP_EN_BIT  = 6;
  localparam int MSG_L2_BIT      = 5;
  localparam int MSG_IPV4_BIT    = 4;
  localparam int MSG_IPV6_BIT    = 3;
  localparam int MSG_P2P_BIT     = 2;
  localparam int MSG_MASTER_BIT  = 1;
  localparam logic [15:0] MSG_RW_MASK   = 16'h007e;
  localparam logic [15:0] MSG_CFG_RESET = 16'h0039;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [31:0]        sec;
    logic [31:0]        ns;
    logic [PHASE_W-1:0] phase;
  } prc_time_t;

  typedef struct packed {
    logic [TICK_CNT_W-1:0] tick_cnt;
    prc_time_t             live;
    logic [31:0]           live_frac;
    prc_time_t             shadow;
    logic [29:0]           rate;
    logic                  rate_dir;
    logic                  temp_active;
    logic [31:0]           dur;
    logic [31:0]           temp_cnt;
    logic                  cont_adj;
    logic                  clk_en;
    logic                  step_dir;
    logic [15:0]           msg_cfg;
    logic                  awready;
    logic                  wready;
    logic                  aw_have;
    logic [31:0]           aw_addr;
    logic                  w_have;
    logic [15:0]           w_data;
    logic [1:0]            w_strb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  arready;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
  } prc_state_t;

endpackage

// file: design/prc_time_step.sv
// one 25MHz advance of the clock time, with optional rate adjustment
`timescale 1ns/10ps
module prc_time_step
  import prc_pkg::*;
(
  input  wire logic [31:0] ns_i,
  input  wire logic [31:0] sec_i,
  input  wire logic [31:0] frac_i,
  input  wire logic [29:0] rate_i,
  input  wire logic        adj_en_i,
  input  wire logic        add_dir_i,
  output logic      [31:0] ns_o,
  output logic      [31:0] sec_o,
  output logic      [31:0] frac_o
);

  logic [32:0] frac_sum;
  logic [32:0] frac_dif;
  logic [32:0] ns_inc;
  logic [32:0] ns_sum;

  always_comb begin
    frac_sum = {1'b0, frac_i} + {3'h0, rate_i};
    frac_dif = {1'b0, frac_i} - {3'h0, rate_i};
    ns_inc   = NOMINAL_NS_33;
    frac_o   = frac_i;
    // the fraction carries or borrows one nanosecond into the nominal step
    if (adj_en_i && add_dir_i) begin
      frac_o = frac_sum[31:0];
      ns_inc = ns_inc + {32'h0, frac_sum[32]};
    end else if (adj_en_i) begin
      frac_o = frac_dif[31:0];
      ns_inc = ns_inc - {32'h0, frac_dif[32]};
    end
    ns_sum = {1'b0, ns_i} + ns_inc;
    ns_o   = ns_sum[31:0];
    sec_o  = sec_i;
    if (ns_sum >= NS_PER_SEC) begin
      ns_o  = 32'(ns_sum - NS_PER_SEC);
      sec_o = sec_i + 32'h1;
    end
  end

endmodule

// file: verification/prc_rtc_properties.sv
// port assertions for the ptp real-time clock top
`timescale 1ns/10ps
module prc_rtc_properties
  import prc_pkg::*;
(
  input wire logic        ref_clk_i,
  input wire logic        reset_n_i,
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_wready_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  input wire logic [31:0] s_axi_rdata_o,
  input wire prc_time_t   time_o,
  input wire logic        clk_running_o,
  input wire logic        temp_adjust_active_o,
  input wire logic        cont_adjust_active_o,
  input wire logic        ptp_mode_en_o,
  input wire logic        detect_l2_en_o,
  input wire logic        detect_ipv4_en_o,
  input wire logic        detect_ipv6_en_o,
  input wire logic        p2p_mode_o,
  input wire logic        host_master_o
);
  default clocking dc @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  logic [5:0] cfg_bits;
  assign cfg_bits = {ptp_mode_en_o, detect_l2_en_o, detect_ipv4_en_o, detect_ipv6_en_o,
                     p2p_mode_o, host_master_o};

  read_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer missing");
  read_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read data not held");
  write_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
    else $error("write response dropped");
  write_block_a: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write taken while response pending");
  cfg_reset_a: assert property ($rose(reset_n_i) |-> cfg_bits == 6'h1c && !clk_running_o)
    else $error("config outputs wrong after reset");
  cfg_steady_a: assert property (!$rose(s_axi_bvalid_o) |-> $stable(cfg_bits))
    else $error("config changed without a write");
  temp_end_a: assert property ($fell(temp_adjust_active_o) |->
    $past(clk_running_o) || $rose(s_axi_bvalid_o)) else $error("temp adjust ended while paused");
  clock_frozen_a: assert property ($past(!clk_running_o) && !$rose(s_axi_bvalid_o) |->
    $stable(time_o)) else $error("time moved while clock disabled");
  // wraps are left out through the seconds change
  nominal_step_a: assert property ($past(clk_running_o && !temp_adjust_active_o &&
    !cont_adjust_active_o) && !$rose(s_axi_bvalid_o) |->
    (time_o.ns - $past(time_o.ns)) inside {32'h0, 32'h28} || time_o.sec != $past(time_o.sec))
    else $error("unadjusted step is not 40 ns");
endmodule

bind prc_rtc_top prc_rtc_properties i_props (.*);

// file: verification/prc_rtc_tb.sv
// self-checking bench for the ptp real-time clock block
`timescale 1ns/10ps
`define CHK(a, b) \
  begin \
    comparisons++; \
    if ((a) !== (b)) begin \
      mismatches++; \
      $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); \
    end \
  end
module testbench
  import prc_pkg::*;
;
  logic        ref_clk;
  logic        reset_n;
  logic [15:0] awaddr;
  logic [15:0] araddr;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        awvalid;
  logic        wvalid;
  logic        bready;
  logic        arvalid;
  logic        rready;
  logic        awready;
  logic        wready;
  logic        bvalid;
  logic        arready;
  logic        rvalid;
  logic [1:0]  bresp;
  logic [1:0]  rresp;
  logic [31:0] rdata;
  prc_time_t   tm;
  logic        running;
  logic        temp_act;
  logic        cont_act;
  wire [5:0]   cfg;
  int          mismatches;
  int          comparisons;

  always #5 ref_clk = ~ref_clk;

  prc_rtc_top i_dut (
    .ref_clk_i(ref_clk), .reset_n_i(reset_n), .s_axi_awaddr_i(awaddr), .s_axi_awprot_i(3'h0),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arprot_i(3'h0), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .time_o(tm), .clk_running_o(running),
    .temp_adjust_active_o(temp_act), .cont_adjust_active_o(cont_act), .ptp_mode_en_o(cfg[5]),
    .detect_l2_en_o(cfg[4]), .detect_ipv4_en_o(cfg[3]), .detect_ipv6_en_o(cfg[2]),
    .p2p_mode_o(cfg[1]), .host_master_o(cfg[0])
  );

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // one edge of spacing at the end keeps bready from being set twice in one step
  task automatic wr(input logic [11:0] idx, input logic [15:0] d, input logic [1:0] er);
    logic a;
    logic w;
    logic done;
    a = 1'b1;
    w = 1'b1;
    done = 1'b0;
    awaddr <= {2'h0, idx, 2'h0};
    wdata <= {16'h0, d};
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    repeat (30) begin
      @(posedge ref_clk);
      if (!a && !w && bvalid === 1'b1) begin
        done = 1'b1;
        break;
      end
      if (a && awready === 1'b1) begin
        a = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready === 1'b1) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end
    `CHK(done, 1'b1)
    `CHK(bresp, er)
    bready <= 1'b0;
    @(posedge ref_clk);
  endtask

  // rready comes one edge late so the slave has to hold its answer
  task automatic chk_rd(input logic [11:0] idx, input logic [15:0] exp, input logic [1:0] er);
    logic a;
    logic done;
    a = 1'b1;
    done = 1'b0;
    araddr <= {2'h0, idx, 2'h0};
    arvalid <= 1'b1;
    repeat (30) begin
      @(posedge ref_clk);
      if (!a && rvalid === 1'b1 && rready === 1'b1) begin
        done = 1'b1;
        break;
      end
      if (!a) rready <= 1'b1;
      if (a && arready === 1'b1) begin
        a = 1'b0;
        arvalid <= 1'b0;
      end
    end
    `CHK(done, 1'b1)
    `CHK(rdata, {16'h0, exp})
    `CHK(rresp, er)
    rready <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic t_reset();
    logic [11:0] idx [11];
    idx = '{IDX_CTRL, IDX_PHASE, IDX_NS_HI, IDX_NS_LO, IDX_SEC_HI, IDX_SEC_LO, IDX_RATE_HI,
            IDX_RATE_LO, IDX_DUR_HI, IDX_DUR_LO, IDX_MSG_CFG1};
    foreach (idx[i]) chk_rd(idx[i], (idx[i] == IDX_MSG_CFG1) ? 16'h0039 : 16'h0, 2'h0);
    `CHK(cfg, 6'h1c)
  endtask

  task automatic t_rw();
    logic [11:0] idx [7];
    idx = '{IDX_NS_HI, IDX_NS_LO, IDX_SEC_HI, IDX_SEC_LO, IDX_RATE_LO, IDX_DUR_HI, IDX_DUR_LO};
    foreach (idx[i]) begin
      wr(idx[i], 16'ha5c3 ^ 16'(i), 2'h0);
      chk_rd(idx[i], 16'ha5c3 ^ 16'(i), 2'h0);
    end
    wr(IDX_RATE_HI, 16'hb234, 2'h0);
    chk_rd(IDX_RATE_HI, 16'hb234, 2'h0);
    wr(12'h516, 16'hffff, 2'h2);
    chk_rd(12'h516, 16'h0, 2'h2);
  endtask

  task automatic t_cfg();
    logic [15:0] w [3];
    w = '{16'h0054, 16'h002a, 16'hffff};
    foreach (w[i]) begin
      wr(IDX_MSG_CFG1, w[i], 2'h0);
      chk_rd(IDX_MSG_CFG1, (w[i] & 16'h007e) | 16'h0001, 2'h0);
      `CHK(cfg, w[i][6:1])
    end
  endtask

  task automatic t_load();
    wr(IDX_NS_HI, 16'h3b9a, 2'h0);
    wr(IDX_NS_LO, 16'hc9d8, 2'h0);
    wr(IDX_SEC_HI, 16'h0000, 2'h0);
    wr(IDX_SEC_LO, 16'h0005, 2'h0);
    wr(IDX_CTRL, 16'h000a, 2'h0);
    `CHK(running, 1'b1)
    repeat (12) begin
      @(posedge ref_clk);
      if (tm.sec === 32'd6) break;
    end
    `CHK(tm.sec, 32'd6)
    `CHK(tm.ns, 32'd0)
    wr(IDX_CTRL, 16'h0000, 2'h0);
    wr(IDX_NS_LO, 16'h0123, 2'h0);
    wr(IDX_CTRL, 16'h0008, 2'h0);
    `CHK(tm.ns, 32'h3b9a0123)
    wr(IDX_NS_LO, 16'h7777, 2'h0);
    wr(IDX_SEC_LO, 16'h7777, 2'h0);
    wr(IDX_CTRL, 16'h0010, 2'h0);
    chk_rd(IDX_NS_LO, 16'h0123, 2'h0);
    chk_rd(IDX_SEC_LO, 16'h0005, 2'h0);
    chk_rd(IDX_CTRL, 16'h0000, 2'h0);
  endtask

  // step both ways by 256 ns, then snapshot and reset in one control write
  task automatic t_step();
    wr(IDX_NS_HI, 16'h0000, 2'h0);
    wr(IDX_NS_LO, 16'h0100, 2'h0);
    wr(IDX_CTRL, 16'h0060, 2'h0);
    `CHK(tm.ns, 32'h3b9a0223)
    wr(IDX_CTRL, 16'h0040, 2'h0);
    `CHK(tm.ns, 32'h3b9a0123)
    wr(IDX_PHASE, 16'hfffc, 2'h0);
    chk_rd(IDX_PHASE, 16'h0004, 2'h0);
    wr(IDX_CTRL, 16'h0011, 2'h0);
    `CHK(tm, 67'h0)
    chk_rd(IDX_NS_LO, 16'h0123, 2'h0);
  endtask

  // rate of one eighth ns per tick: the tick count follows from the 40 ns part
  task automatic t_cont(input logic up);
    logic [31:0] dn;
    logic [31:0] k;
    wr(IDX_RATE_LO, 16'h0000, 2'h0);
    wr(IDX_RATE_HI, up ? 16'ha000 : 16'h2000, 2'h0);
    wr(IDX_NS_HI, 16'h0000, 2'h0);
    wr(IDX_NS_LO, 16'h03e8, 2'h0);
    wr(IDX_CTRL, 16'h000e, 2'h0);
    `CHK(cont_act, 1'b1)
    repeat (200) @(posedge ref_clk);
    wr(IDX_CTRL, 16'h0000, 2'h0);
    dn = tm.ns - 32'd1000;
    k = up ? dn / 40 : (dn + 39) / 40;
    if (up) `CHK(dn % 40, k / 8)
    else `CHK(40 * k - dn, (k + 7) / 8)
  endtask

  task automatic t_temp();
    wr(IDX_NS_LO, 16'h0000, 2'h0);
    wr(IDX_CTRL, 16'h0008, 2'h0);
    wr(IDX_DUR_HI, 16'h0000, 2'h0);
    wr(IDX_DUR_LO, 16'h0010, 2'h0);
    wr(IDX_RATE_HI, 16'he000, 2'h0);
    `CHK(temp_act, 1'b1)
    chk_rd(IDX_RATE_HI, 16'he000, 2'h0);
    wr(IDX_CTRL, 16'h0002, 2'h0);
    repeat (100) begin
      @(posedge ref_clk);
      if (temp_act === 1'b0) break;
    end
    `CHK(temp_act, 1'b0)
    repeat (40) @(posedge ref_clk);
    wr(IDX_CTRL, 16'h0000, 2'h0);
    `CHK(tm.ns % 40, 32'd2)
    chk_rd(IDX_RATE_HI, 16'ha000, 2'h0);
    wr(IDX_RATE_HI, 16'he000, 2'h0);
    wr(IDX_RATE_HI, 16'ha000, 2'h0);
    `CHK(temp_act, 1'b0)
    wr(IDX_CTRL, 16'h0002, 2'h0);
    repeat (100) @(posedge ref_clk);
    wr(IDX_CTRL, 16'h0000, 2'h0);
    `CHK(tm.ns % 40, 32'd2)
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    end_sim();
  end

  initial begin
    ref_clk = 1'b0;
    reset_n = 1'b0;
    awaddr = 16'h0;
    araddr = 16'h0;
    wdata = 32'h0;
    wstrb = 4'h0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    mismatches = 0;
    comparisons = 0;
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    t_reset();
    t_rw();
    t_cfg();
    t_load();
    t_step();
    t_cont(1'b1);
    t_cont(1'b0);
    t_temp();
    end_sim();
  end
endmodule
